// file: include/dpvrm_pkg.sv
// dpvrm_pkg: constants, types and the register map of the digipot volatile register map.
// assumes a serial front end that decodes frames into parallel commands on one clock.
package dpvrm_pkg;

    // register geometry
    localparam int unsigned DATA_W = 9;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned NUM_LOCATIONS = 16;
    localparam int unsigned NUM_NETS = 2;

    // register offsets
    localparam logic [3:0] ADDR_WIPER_ZERO_POSITION = 4'h0;
    localparam logic [3:0] ADDR_WIPER_ONE_POSITION = 4'h1;
    localparam logic [3:0] ADDR_TERMINAL_CONNECT_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_DEVICE_STATE_FLAGS = 4'h5;

    // reset values
    localparam logic [8:0] TERMINAL_CONNECT_CONTROL_RESET = 9'h1ff;
    localparam logic [8:0] RESERVED_READ_VALUE = 9'h000;

    // terminal control field positions; network n uses base n * TERMINAL_CONNECT_CONTROL_NET_STRIDE
    localparam int unsigned TERMINAL_CONNECT_CONTROL_NET_STRIDE = 4;
    localparam int unsigned TERMINAL_CONNECT_CONTROL_B_POS = 0;
    localparam int unsigned TERMINAL_CONNECT_CONTROL_W_POS = 1;
    localparam int unsigned TERMINAL_CONNECT_CONTROL_A_POS = 2;
    localparam int unsigned TERMINAL_CONNECT_CONTROL_HW_POS = 3;
    localparam int unsigned TERMINAL_CONNECT_CONTROL_FIXED_POS = 8;

    // device state flags field positions and fixed contents
    localparam int unsigned STAT_UPPER_LSB = 5;
    localparam logic [3:0] STAT_UPPER_FIXED_ONE_BITS = 4'hf;
    localparam int unsigned STAT_HW_POWER_DOWN_INPUT_POS = 1;
    localparam logic [8:0] STAT_UNUSED_STATUS_BIT_MASK = 9'h01d;

    // pin synchroniser length
    localparam int unsigned SYNC_STAGES = 3;

    // command operations from the serial front end
    typedef enum logic [1:0] {
        DPVRM_OP_WRITE = 2'h0,
        DPVRM_OP_INC = 2'h1,
        DPVRM_OP_DEC = 2'h2,
        DPVRM_OP_READ = 2'h3
    } dpvrm_op_t;

    // power sequencing states, one-hot
    typedef enum logic [2:0] {
        DPVRM_PWR_OFF = 3'h1,
        DPVRM_PWR_LOAD = 3'h2,
        DPVRM_PWR_RUN = 3'h4
    } dpvrm_pwr_t;

    typedef struct packed {
        dpvrm_op_t op;
        logic [3:0] addr;
        logic [8:0] wdata;
    } dpvrm_cmd_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic [8:0] rdata;
    } dpvrm_rsp_t;

    // switch state of one resistor network
    typedef struct packed {
        logic conn_a;
        logic conn_w;
        logic conn_b;
        logic wiper_on_b;
    } dpvrm_net_sw_t;

endpackage

// file: src/dpvrm_sync.sv
// dpvrm_sync: three-stage input synchroniser with agreement filter.
// assumes inputs arrive asynchronously from pins or analog comparators.
`timescale 1ns/1ps
`default_nettype none
module dpvrm_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // s1 feeds only s2, nothing else looks at it
    always_ff @(posedge clk) begin
        s1_r <= async_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // a bit changes only once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_out <= RESET_VAL;
        end else begin
            for (int i = 0; i < int'(WIDTH); i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // dpvrm_sync
`default_nettype wire

// file: src/dpvrm_top.sv
// dpvrm_top: volatile register map of a single or dual digital potentiometer.
// assumes a serial front end on clk presenting decoded commands and a completion strobe,
// a supply comparator level and the active-low shutdown pin, both asynchronous.
//
// Functional notes
// - supply rising past trip loads wiper defaults
// - every supply reset loads terminal control 1FFh
// - below trip, all command traffic is ignored
// - low-but-above-trip supply still executes all commands
// - interrupted command may corrupt its location
// - sixteen locations, nine bits each
// - wipers at 00h/01h, control at 04h
// - second wiper exists in dual variant only
// - flags at 05h, read only
// - flag bits 8 to 5 read one
// - flag bit 1 reads one while the live shutdown pin is low
// - shutdown opens A, wiper onto B
// - commands keep working during shutdown
// - control holds four bits per network
// - A, B, W switch independently per bit
// - control write reaches switches at command end
// - low shutdown input forces shutdown state
// - wiper-connect bit one connects, zero disconnects
`timescale 1ns/1ps
`default_nettype none
module dpvrm_top #(
    parameter bit DUAL_NET = 1'b1,
    parameter logic [8:0] WIPER_DEFAULT = 9'h080,
    parameter logic [8:0] WIPER_FULL_SCALE = 9'h100
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic supply_above_trip,
    input wire logic hw_power_down_input_n,
    input wire logic cmd_valid,
    input wire dpvrm_pkg::dpvrm_cmd_t cmd,
    input wire logic cmd_end,
    output dpvrm_pkg::dpvrm_rsp_t rsp,
    output logic link_enabled,
    output logic [8:0] wiper_zero_pos,
    output logic [8:0] wiper_one_pos,
    output dpvrm_pkg::dpvrm_net_sw_t [dpvrm_pkg::NUM_NETS-1:0] net_sw
);

    // synchronised pin levels
    logic [1:0] pins_sync;
    logic supply_ok;
    logic hw_power_down_input_active;

    dpvrm_sync #(
        .WIDTH(2),
        .RESET_VAL(2'h1)
    ) u_pin_sync (
        .clk(clk),
        .srst(srst),
        .async_in({supply_above_trip, hw_power_down_input_n}),
        .sync_out(pins_sync)
    );

    assign supply_ok = pins_sync[1];
    assign hw_power_down_input_active = ~pins_sync[0];

    // power sequencing
    dpvrm_pkg::dpvrm_pwr_t pwr_r;
    dpvrm_pkg::dpvrm_pwr_t pwr_nxt;
    logic run;
    logic load_now;

    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            dpvrm_pkg::DPVRM_PWR_OFF: begin
                if (supply_ok) begin
                    pwr_nxt = dpvrm_pkg::DPVRM_PWR_LOAD;
                end
            end
            dpvrm_pkg::DPVRM_PWR_LOAD: begin
                // defaults land on the edge leaving this state, the same edge that raises link_enabled
                pwr_nxt = supply_ok ? dpvrm_pkg::DPVRM_PWR_RUN : dpvrm_pkg::DPVRM_PWR_OFF;
            end
            dpvrm_pkg::DPVRM_PWR_RUN: begin
                if (!supply_ok) begin
                    pwr_nxt = dpvrm_pkg::DPVRM_PWR_OFF;
                end
            end
            default: begin
                pwr_nxt = dpvrm_pkg::DPVRM_PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_r <= dpvrm_pkg::DPVRM_PWR_OFF;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // only the supply level gates the link; shutdown does not
    assign run = (pwr_r == dpvrm_pkg::DPVRM_PWR_RUN);
    assign load_now = (pwr_r == dpvrm_pkg::DPVRM_PWR_LOAD);

    always_ff @(posedge clk) begin
        if (srst) begin
            link_enabled <= 1'b0;
        end else begin
            link_enabled <= (pwr_nxt == dpvrm_pkg::DPVRM_PWR_RUN);
        end
    end

    // command decode
    logic take;
    logic addr_w0;
    logic addr_w1;
    logic addr_terminal_connect_control;
    logic addr_stat;
    logic is_write;
    logic is_step;
    logic is_read;

    assign take = cmd_valid && run;
    assign addr_w0 = (cmd.addr == dpvrm_pkg::ADDR_WIPER_ZERO_POSITION);
    assign addr_w1 = DUAL_NET && (cmd.addr == dpvrm_pkg::ADDR_WIPER_ONE_POSITION);
    assign addr_terminal_connect_control = (cmd.addr == dpvrm_pkg::ADDR_TERMINAL_CONNECT_CONTROL);
    assign addr_stat = (cmd.addr == dpvrm_pkg::ADDR_DEVICE_STATE_FLAGS);
    assign is_write = (cmd.op == dpvrm_pkg::DPVRM_OP_WRITE);
    assign is_read = (cmd.op == dpvrm_pkg::DPVRM_OP_READ);
    assign is_step = (cmd.op == dpvrm_pkg::DPVRM_OP_INC) || (cmd.op == dpvrm_pkg::DPVRM_OP_DEC);

    // saturating wiper step; writes above full scale are clamped too
    function automatic logic [8:0] wiper_apply(
        input logic [8:0] cur,
        input dpvrm_pkg::dpvrm_op_t op,
        input logic [8:0] wdata,
        input logic [8:0] full
    );
        logic [8:0] res;
        res = cur;
        unique case (op)
            dpvrm_pkg::DPVRM_OP_WRITE: res = (wdata > full) ? full : wdata;
            dpvrm_pkg::DPVRM_OP_INC: res = (cur >= full) ? full : cur + 9'h001;
            dpvrm_pkg::DPVRM_OP_DEC: res = (cur == 9'h000) ? 9'h000 : cur - 9'h001;
            dpvrm_pkg::DPVRM_OP_READ: res = cur;
        endcase
        return res;
    endfunction

    // wiper registers
    logic [8:0] wiper_zero_r;
    logic [8:0] wiper_one_r;

    always_ff @(posedge clk) begin
        if (srst || load_now) begin
            wiper_zero_r <= WIPER_DEFAULT;
            wiper_one_r <= DUAL_NET ? WIPER_DEFAULT : 9'h000;
        end else if (take && !is_read) begin
            // a frame cut by brown-out may leave a partial value here
            if (addr_w0) begin
                wiper_zero_r <= wiper_apply(wiper_zero_r, cmd.op, cmd.wdata, WIPER_FULL_SCALE);
            end
            if (addr_w1) begin
                wiper_one_r <= wiper_apply(wiper_one_r, cmd.op, cmd.wdata, WIPER_FULL_SCALE);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wiper_zero_pos <= WIPER_DEFAULT;
            wiper_one_pos <= DUAL_NET ? WIPER_DEFAULT : 9'h000;
        end else begin
            wiper_zero_pos <= wiper_zero_r;
            wiper_one_pos <= wiper_one_r;
        end
    end

    // terminal control: readable copy and the copy that drives the switches
    logic [8:0] terminal_connect_control_r;
    logic [8:0] terminal_connect_control_act_r;
    logic [8:0] terminal_connect_control_nxt;
    logic terminal_connect_control_wr;

    assign terminal_connect_control_wr = take && is_write && addr_terminal_connect_control;
    // bit 8 is fixed high, the other eight follow the write
    assign terminal_connect_control_nxt = terminal_connect_control_wr ? {1'b1, cmd.wdata[7:0]} : terminal_connect_control_r;

    always_ff @(posedge clk) begin
        if (srst || load_now) begin
            terminal_connect_control_r <= dpvrm_pkg::TERMINAL_CONNECT_CONTROL_RESET;
        end else begin
            terminal_connect_control_r <= terminal_connect_control_nxt;
        end
    end

    // control writes move the switches only on the frame's completion, never mid-frame
    always_ff @(posedge clk) begin
        if (srst || load_now) begin
            terminal_connect_control_act_r <= dpvrm_pkg::TERMINAL_CONNECT_CONTROL_RESET;
        end else if (run && cmd_end) begin
            terminal_connect_control_act_r <= terminal_connect_control_nxt;
        end
    end

    // per-network decode of the applied control bits
    function automatic dpvrm_pkg::dpvrm_net_sw_t net_decode(
        input logic [8:0] ctl,
        input int unsigned net,
        input logic pin_hw_power_down_input
    );
        dpvrm_pkg::dpvrm_net_sw_t sw;
        int unsigned base;
        logic down;
        base = net * dpvrm_pkg::TERMINAL_CONNECT_CONTROL_NET_STRIDE;
        // a cleared hardware-config bit forces the same state as the pin
        down = pin_hw_power_down_input || !ctl[base + dpvrm_pkg::TERMINAL_CONNECT_CONTROL_HW_POS];
        sw.conn_a = ctl[base + dpvrm_pkg::TERMINAL_CONNECT_CONTROL_A_POS] && !down;
        sw.conn_w = ctl[base + dpvrm_pkg::TERMINAL_CONNECT_CONTROL_W_POS];
        sw.conn_b = ctl[base + dpvrm_pkg::TERMINAL_CONNECT_CONTROL_B_POS];
        sw.wiper_on_b = down;
        return sw;
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            net_sw <= '0;
        end else begin
            for (int n = 0; n < int'(dpvrm_pkg::NUM_NETS); n++) begin
                if (n == 0 || DUAL_NET) begin
                    net_sw[n] <= net_decode(terminal_connect_control_act_r, n, hw_power_down_input_active);
                end else begin
                    net_sw[n] <= '0;
                end
            end
        end
    end

    // device state flags, rebuilt each cycle from live state
    logic [8:0] stat_val;

    always_comb begin
        stat_val = '0; // unused status bits read zero
        stat_val[8:dpvrm_pkg::STAT_UPPER_LSB] = dpvrm_pkg::STAT_UPPER_FIXED_ONE_BITS;
        stat_val[dpvrm_pkg::STAT_HW_POWER_DOWN_INPUT_POS] = hw_power_down_input_active;
    end

    // read mux over the sixteen-location space
    function automatic logic [8:0] read_mux(
        input logic [3:0] addr,
        input logic [8:0] w0,
        input logic [8:0] w1,
        input logic [8:0] tc,
        input logic [8:0] st
    );
        logic [8:0] v;
        v = dpvrm_pkg::RESERVED_READ_VALUE;
        unique case (addr)
            dpvrm_pkg::ADDR_WIPER_ZERO_POSITION: v = w0;
            dpvrm_pkg::ADDR_WIPER_ONE_POSITION: v = DUAL_NET ? w1 : v;
            dpvrm_pkg::ADDR_TERMINAL_CONNECT_CONTROL: v = tc;
            dpvrm_pkg::ADDR_DEVICE_STATE_FLAGS: v = st;
            default: v = dpvrm_pkg::RESERVED_READ_VALUE;
        endcase
        return v;
    endfunction

    // an access is refused when it names no location for that operation
    logic cmd_legal;

    always_comb begin
        cmd_legal = 1'b0;
        if (is_read) begin
            cmd_legal = addr_w0 || addr_w1 || addr_terminal_connect_control || addr_stat;
        end else if (is_write) begin
            cmd_legal = addr_w0 || addr_w1 || addr_terminal_connect_control;
        end else if (is_step) begin
            cmd_legal = addr_w0 || addr_w1;
        end
    end

    // one answer per accepted command, one cycle later
    always_ff @(posedge clk) begin
        if (srst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= take;
            rsp.error <= take && !cmd_legal;
            if (take) begin
                rsp.rdata <= read_mux(cmd.addr, wiper_zero_r, wiper_one_r, terminal_connect_control_r, stat_val);
            end
        end
    end

endmodule // dpvrm_top
`default_nettype wire

// file: tb/dpvrm_checker.sv
// dpvrm_checker: port-level assertions for dpvrm_top.
// assumes every port is on clk and that the host never overlaps frame ends.
`timescale 1ns/1ps
`default_nettype none
module dpvrm_checker #(
    parameter logic [8:0] WIPER_FULL_SCALE = 9'h100
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic supply_above_trip,
    input wire logic hw_power_down_input_n,
    input wire logic cmd_valid,
    input wire dpvrm_pkg::dpvrm_cmd_t cmd,
    input wire logic cmd_end,
    input wire dpvrm_pkg::dpvrm_rsp_t rsp,
    input wire logic link_enabled,
    input wire logic [8:0] wiper_zero_pos,
    input wire logic [8:0] wiper_one_pos,
    input wire dpvrm_pkg::dpvrm_net_sw_t [dpvrm_pkg::NUM_NETS-1:0] net_sw
);
    logic tk;
    logic pin_r;
    logic [3:0] quiet_r;
    assign tk = cmd_valid && link_enabled;
    // switches may only move after a frame end, a pin change or a reload
    always_ff @(posedge clk) begin
        pin_r <= hw_power_down_input_n;
        if (srst || cmd_end || !link_enabled || pin_r != hw_power_down_input_n) begin
            quiet_r <= 4'h0;
        end else if (quiet_r != 4'hf) begin
            quiet_r <= quiet_r + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_RSP_TIMING: assert property (tk |=> rsp.valid)
        else $error("no response after a taken command");
    AST_QUIET_OFF: assert property (!link_enabled |=> !rsp.valid)
        else $error("response while the link is disabled");
    AST_LINK_DROP: assert property (!supply_above_trip [*8] |-> !link_enabled)
        else $error("link still enabled with supply low");
    AST_FLAG_ONES: assert property (
        tk && cmd.op == dpvrm_pkg::DPVRM_OP_READ && cmd.addr == 4'h5
        |=> rsp.rdata[8:5] == 4'hf) else $error("flag upper bits not one");
    AST_FLAG_RO: assert property (
        tk && cmd.op == dpvrm_pkg::DPVRM_OP_WRITE && cmd.addr == 4'h5
        |=> rsp.error) else $error("flag write not refused");
    AST_RSVD_READ: assert property (
        tk && cmd.op == dpvrm_pkg::DPVRM_OP_READ
        && (cmd.addr == 4'h2 || cmd.addr == 4'h3 || cmd.addr >= 4'h6)
        |=> rsp.error && rsp.rdata == 9'h000) else $error("reserved read");
    AST_HW_POWER_DOWN_INPUT_FORCE: assert property (
        (!hw_power_down_input_n && link_enabled) [*8]
        |-> net_sw[0].wiper_on_b && !net_sw[0].conn_a && net_sw[1].wiper_on_b && !net_sw[1].conn_a)
        else $error("shutdown state not forced");
    AST_TERMINAL_CONNECT_CONTROL_APPLY: assert property (
        tk && cmd_end && cmd.op == dpvrm_pkg::DPVRM_OP_WRITE
        && cmd.addr == 4'h4 |-> ##2 net_sw[0].conn_w == $past(cmd.wdata[1], 2)
        && net_sw[0].conn_b == $past(cmd.wdata[0], 2) && net_sw[1].conn_w == $past(cmd.wdata[5], 2)
        && net_sw[1].conn_b == $past(cmd.wdata[4], 2)) else $error("switches wrong");
    AST_TERMINAL_CONNECT_CONTROL_HOLD: assert property (quiet_r >= 4'h8 |-> $stable(net_sw))
        else $error("switches moved without a frame end");
    AST_WIPER0_WRITE: assert property (
        tk && cmd.op == dpvrm_pkg::DPVRM_OP_WRITE && cmd.addr == 4'h0
        && cmd.wdata <= WIPER_FULL_SCALE ##1 !cmd_valid |-> ##1 wiper_zero_pos == $past(cmd.wdata, 2))
        else $error("wiper 0 output wrong");
    cover property (tk && cmd_end);
    cover property (!hw_power_down_input_n && rsp.valid);
    cover property ($fell(link_enabled));
endmodule // dpvrm_checker
bind dpvrm_top dpvrm_checker #(.WIPER_FULL_SCALE(WIPER_FULL_SCALE)) u_chk (.clk(clk), .srst(srst),
    .supply_above_trip(supply_above_trip), .hw_power_down_input_n(hw_power_down_input_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_end(cmd_end), .rsp(rsp), .link_enabled(link_enabled),
    .wiper_zero_pos(wiper_zero_pos), .wiper_one_pos(wiper_one_pos), .net_sw(net_sw));
`default_nettype wire

// file: tb/dpvrm_host_model.sv
// dpvrm_host_model: host side of the command port, sends commands and frame ends.
// assumes one calling process; each send holds for one edge.
`timescale 1ns/1ps
`default_nettype none
module dpvrm_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output dpvrm_pkg::dpvrm_cmd_t cmd,
    output logic cmd_end
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        cmd_end = 1'b0;
    end
    task automatic send(input dpvrm_pkg::dpvrm_op_t o, input logic [3:0] a, input logic [8:0] d,
            input logic e);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: o, addr: a, wdata: d};
        cmd_end <= e;
    endtask
    // released fields toggle so a stale command never looks live
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            cmd_valid <= 1'b0;
            cmd_end <= 1'b0;
            cmd <= ~cmd;
        end
    endtask
endmodule // dpvrm_host_model
`default_nettype wire

// file: tb/dpvrm_top_tb_top.sv
// dpvrm_top_tb_top: self-checking bench for the volatile register map.
// assumes the host model owns the command port; the bench owns supply and pin.
`timescale 1ns/1ps
`default_nettype none
module dpvrm_top_tb_top;
    localparam dpvrm_pkg::dpvrm_op_t WR = dpvrm_pkg::DPVRM_OP_WRITE;
    localparam dpvrm_pkg::dpvrm_op_t RD = dpvrm_pkg::DPVRM_OP_READ;
    localparam dpvrm_pkg::dpvrm_op_t INC = dpvrm_pkg::DPVRM_OP_INC;
    localparam dpvrm_pkg::dpvrm_op_t DEC = dpvrm_pkg::DPVRM_OP_DEC;
    logic clk, srst, supply_above_trip, hw_power_down_input_n, cmd_valid, cmd_end, link_enabled;
    dpvrm_pkg::dpvrm_cmd_t cmd;
    dpvrm_pkg::dpvrm_rsp_t rsp;
    dpvrm_pkg::dpvrm_net_sw_t [1:0] net_sw;
    logic [8:0] wiper_zero_pos, wiper_one_pos, w0, r, tc, tcv;
    logic [10:0] exp_q[$], msk_q[$];
    int mismatches = 0;
    int tests_run = 0;
    dpvrm_top uut (
        .clk(clk), .srst(srst), .supply_above_trip(supply_above_trip),
        .hw_power_down_input_n(hw_power_down_input_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_end(cmd_end), .rsp(rsp), .link_enabled(link_enabled), .wiper_zero_pos(wiper_zero_pos),
        .wiper_one_pos(wiper_one_pos), .net_sw(net_sw));
    dpvrm_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_end(cmd_end));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // mask clears rdata bits the bench does not predict, such as after inc or dec
    task automatic op(input dpvrm_pkg::dpvrm_op_t o, input logic [3:0] a, input logic [8:0] d,
            input logic err, input logic [8:0] ed, input logic [8:0] m = 9'h1ff, input logic e = 0);
        host.send(o, a, d, e);
        exp_q.push_back({1'b1, err, ed});
        msk_q.push_back({2'b11, m});
    endtask
    function automatic logic [7:0] sw_of(input logic [8:0] v, input logic dn);
        logic [7:0] s;
        for (int n = 0; n < 2; n++) begin
            s[4*n +: 4] = {v[4*n+2] & v[4*n+3] & !dn, v[4*n+1], v[4*n], !v[4*n+3] | dn};
        end
        return s;
    endfunction
    task automatic chk_sw(input logic [8:0] v, input logic dn);
        #1;
        check({3'h0, net_sw}, {3'h0, sw_of(v, dn)});
    endtask
    task automatic wait_link();
        repeat (40) begin
            @(posedge clk);
            if (link_enabled === 1'b1) break;
        end
        check({10'h0, link_enabled}, 11'h001);
    endtask
    always @(posedge clk) begin
        logic [10:0] m;
        // rsp is unknown until the first reset edge, so only look once reset is over
        if (!srst && rsp.valid !== 1'b0) begin
            if (exp_q.size() == 0) begin
                check(rsp, 11'h000);
            end else begin
                m = msk_q.pop_front();
                check(rsp & m, exp_q.pop_front() & m);
            end
        end
    end
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
    initial begin
        srst = 1'b1;
        supply_above_trip = 1'b1;
        hw_power_down_input_n = 1'b1;
        void'($urandom(32'h4a270d1c));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        wait_link();
        op(RD, 4'h0, 9'h000, 1'b0, 9'h080);
        op(RD, 4'h1, 9'h000, 1'b0, 9'h080);
        op(RD, 4'h4, 9'h000, 1'b0, 9'h1ff);
        op(RD, 4'h5, 9'h000, 1'b0, 9'h1e0);
        for (int a = 2; a < 16; a++) begin
            if (a != 4 && a != 5) begin
                op(WR, 4'(a), 9'h155, 1'b1, 9'h000, 9'h000);
                op(RD, 4'(a), 9'h000, 1'b1, 9'h000);
            end
        end
        r = 9'($urandom % 257);
        w0 = (r == 9'h000) ? 9'h000 : r - 9'h001;
        op(WR, 4'h0, r, 1'b0, 9'h080);
        op(WR, 4'h1, 9'h100, 1'b0, 9'h080);
        op(INC, 4'h1, 9'h000, 1'b0, 9'h000, 9'h000);
        op(DEC, 4'h0, 9'h000, 1'b0, 9'h000, 9'h000);
        op(RD, 4'h0, 9'h000, 1'b0, w0);
        op(RD, 4'h1, 9'h000, 1'b0, 9'h100);
        op(WR, 4'h1, 9'h000, 1'b0, 9'h100);
        op(DEC, 4'h1, 9'h000, 1'b0, 9'h000, 9'h000);
        op(RD, 4'h1, 9'h000, 1'b0, 9'h000);
        op(WR, 4'h5, 9'h000, 1'b1, 9'h000, 9'h000);
        op(INC, 4'h4, 9'h000, 1'b1, 9'h000, 9'h000);
        op(RD, 4'h5, 9'h000, 1'b0, 9'h1e0);
        op(WR, 4'h4, 9'h0fe, 1'b0, 9'h1ff);
        host.idle(3);
        chk_sw(9'h1ff, 1'b0);
        check({2'h0, wiper_one_pos}, 11'h000);
        op(RD, 4'h4, 9'h000, 1'b0, 9'h1fe, 9'h1ff, 1'b1);
        host.idle(3);
        chk_sw(9'h1fe, 1'b0);
        tcv = 9'h1fe;
        for (int i = 0; i < 4; i++) begin
            tc = 9'($urandom);
            op(WR, 4'h4, tc, 1'b0, tcv, 9'h1ff, 1'b1);
            host.idle(3);
            tcv = {1'b1, tc[7:0]};
            chk_sw(tcv, 1'b0);
        end
        @(posedge clk);
        hw_power_down_input_n <= 1'b0;
        host.idle(8);
        op(RD, 4'h5, 9'h000, 1'b0, 9'h1e2);
        host.idle(2);
        chk_sw(tcv, 1'b1);
        @(posedge clk);
        hw_power_down_input_n <= 1'b1;
        host.idle(8);
        op(RD, 4'h5, 9'h000, 1'b0, 9'h1e0);
        r = 9'($urandom % 257);
        op(WR, 4'h0, r, 1'b0, w0);
        host.idle(3);
        #1;
        check({2'h0, wiper_zero_pos}, {2'h0, r});
        @(posedge clk);
        supply_above_trip <= 1'b0;
        host.idle(12);
        #1;
        check({10'h0, link_enabled}, 11'h000);
        host.send(WR, 4'h0, 9'h011, 1'b0);
        host.idle(2);
        supply_above_trip <= 1'b1;
        wait_link();
        op(RD, 4'h0, 9'h000, 1'b0, 9'h080);
        op(RD, 4'h4, 9'h000, 1'b0, 9'h1ff);
        op(WR, 4'h4, tcv, 1'b0, 9'h1ff, 9'h1ff, 1'b1);
        host.idle(3);
        chk_sw(tcv, 1'b0);
        host.idle(4);
        check({2'h0, 9'(exp_q.size())}, 11'h000);
        final_report();
    end
endmodule // dpvrm_top_tb_top
`default_nettype wire
